// ==== pkg/coe_wake_pkg.sv ====
package coe_wake_pkg;

	// ----------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------
	// Printed offsets are not all multiples of four, so they are indices.
	localparam logic [7:0] checksum_offload_control_idx = 8'h0D;
	localparam logic [7:0] post_idle_tx_wait_time_idx = 8'h0E;
	localparam int addr_w = 8;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int rx_engine_enable_bit = 0;
	localparam int rx_start_select_bit = 1;
	localparam int tx_engine_enable_bit = 16;
	localparam int wait_field_w = 24;
	localparam logic [23:0] wait_time_reset = 24'h00001E;
	localparam logic rx_engine_enable_reset = 1'h0;
	localparam logic rx_start_select_reset = 1'h0;
	localparam logic tx_engine_enable_reset = 1'h0;

	// ----------------------------------------------------------------
	// Timing and frame constants.
	// ----------------------------------------------------------------
	localparam int clk_freq_mhz = 50;
	localparam int us_ns = 1000;
	localparam int clk_period_ns = 20;
	localparam int cycles_per_us = us_ns / clk_period_ns;
	localparam logic [5:0] us_tick_last = 6'(cycles_per_us - 1);
	localparam logic [4:0] fixed_l3_offset = 5'h0E;
	localparam logic [4:0] vlan_tag_len = 5'h04;
	localparam logic [4:0] snap_hdr_len = 5'h08;
	localparam logic [15:0] vlan_tpid = 16'h8100;
	localparam logic [15:0] max_len_field = 16'h05DC;
	localparam logic [7:0] snap_llc_byte = 8'hAA;

	// ----------------------------------------------------------------
	// Carriers.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tx_engine_enable;
		logic rx_start_select;
		logic rx_engine_enable;
	} coe_cfg_t;

	typedef struct packed {
		logic valid;
		logic sof;
		logic [7:0] data;
	} rx_byte_t;

endpackage : coe_wake_pkg

// ==== rtl/coe_wake_cfg.sv ====
// Behaviour
// - Transmit checksum engine runs only while bit 16 is set; resets clear.
// - With start-select clear the receive checksum starts at frame byte 14.
// - With start-select set VLAN and SNAP are skipped to the layer-3 start.
// - Receive checksum engine runs only while bit 0 is set; resets clear.
// - After idle removal transmission waits the 24-bit microsecond count.
// - The wait field resets to 1E hex, thirty microseconds.
module coe_wake_cfg (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave.
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// MAC side.
	input wire coe_wake_pkg::rx_byte_t rx_in,
	input wire logic lpi_removed,
	output coe_wake_pkg::coe_cfg_t cfg,
	output logic rx_csum_start,
	output logic tx_hold
);

	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------
	coe_wake_pkg::coe_cfg_t cfg_r;
	logic [23:0] wait_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [7:0] widx_r;
	logic aw_held_r;
	logic w_held_r;
	logic bvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [1:0] bresp_r;
	logic rvalid_r;

	// ----------------------------------------------------------------
	// Write channel decode.
	// ----------------------------------------------------------------
	// Address and data are captured independently so either may lead.
	logic aw_take;
	logic w_take;
	logic do_write;
	logic hit_coe;
	logic hit_wait;
	logic [31:0] wr_word;
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign do_write = aw_held_r && w_held_r;
	assign hit_coe = widx_r == coe_wake_pkg::checksum_offload_control_idx;
	assign hit_wait = widx_r == coe_wake_pkg::post_idle_tx_wait_time_idx;

	// Merge the byte lanes with the current register contents.
	logic [31:0] cur_word;
	assign cur_word = hit_coe ? {15'h0000, cfg_r.tx_engine_enable, 14'h0000,
		cfg_r.rx_start_select, cfg_r.rx_engine_enable} : {8'h00, wait_r};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wr_word[gi*8 +: 8] = wstrb_r[gi] ? wdata_r[gi*8 +: 8]
				: cur_word[gi*8 +: 8];
		end
	endgenerate

	// Capture of address and data, then commit once both are held.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			widx_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				widx_r <= s_axi_awaddr[9:2];
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// Register update; only defined bits are stored.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r.tx_engine_enable <= coe_wake_pkg::tx_engine_enable_reset;
			cfg_r.rx_start_select <= coe_wake_pkg::rx_start_select_reset;
			cfg_r.rx_engine_enable <= coe_wake_pkg::rx_engine_enable_reset;
			wait_r <= coe_wake_pkg::wait_time_reset;
		end else if (do_write && hit_coe) begin
			cfg_r.tx_engine_enable <=
				wr_word[coe_wake_pkg::tx_engine_enable_bit];
			cfg_r.rx_start_select <= wr_word[coe_wake_pkg::rx_start_select_bit];
			cfg_r.rx_engine_enable <=
				wr_word[coe_wake_pkg::rx_engine_enable_bit];
		end else if (do_write && hit_wait) begin
			wait_r <= wr_word[coe_wake_pkg::wait_field_w-1:0];
		end
	end

	// Write response: unmapped addresses answer SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= 2'b00;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r <= (hit_coe || hit_wait) ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ----------------------------------------------------------------
	// Read channel.
	// ----------------------------------------------------------------
	logic [7:0] ridx;
	logic r_coe;
	logic r_wait;
	logic [31:0] rd_word;
	assign s_axi_arready = !rvalid_r;
	assign ridx = s_axi_araddr[9:2];
	assign r_coe = ridx == coe_wake_pkg::checksum_offload_control_idx;
	assign r_wait = ridx == coe_wake_pkg::post_idle_tx_wait_time_idx;
	// Reserved positions are forced to zero on the way out.
	assign rd_word = r_coe ? {15'h0000, cfg_r.tx_engine_enable, 14'h0000,
		cfg_r.rx_start_select, cfg_r.rx_engine_enable}
		: r_wait ? {8'h00, wait_r} : 32'h00000000;

	// Read data registered one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'b00;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= (r_coe || r_wait) ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ----------------------------------------------------------------
	// Checksum engine controls.
	// ----------------------------------------------------------------
	// Settings go straight to the engines; software keeps the paths idle
	// while changing them, so no shadow copy is kept here.
	assign cfg = cfg_r;

	logic csum_start_raw;
	rx_l3_locator rx_l3_locator_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.adaptive(cfg_r.rx_start_select),
		.rx_in(rx_in),
		.csum_start(csum_start_raw)
	);
	// A bypassed receive engine gets no start marker.
	assign rx_csum_start = csum_start_raw && cfg_r.rx_engine_enable;

	// ----------------------------------------------------------------
	// Post-idle transmit hold-off.
	// ----------------------------------------------------------------
	// A one-microsecond enable from a divider paces the wait count.
	logic [5:0] div_r;
	logic us_tick;
	logic [23:0] hold_r;
	logic active_r;
	assign us_tick = div_r == coe_wake_pkg::us_tick_last;

	always_ff @(posedge aclk) begin
		if (!aresetn || lpi_removed) begin
			div_r <= 6'h00;
		end else begin
			div_r <= us_tick ? 6'h00 : div_r + 6'h01;
		end
	end

	// Wait is loaded on idle removal and counted down per microsecond.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_r <= 24'h000000;
			active_r <= 1'b0;
		end else if (lpi_removed) begin
			hold_r <= wait_r;
			active_r <= wait_r != 24'h000000;
		end else if (active_r && us_tick) begin
			hold_r <= hold_r - 24'h000001;
			active_r <= hold_r != 24'h000001;
		end
	end
	assign tx_hold = active_r;

endmodule : coe_wake_cfg

// ==== rtl/rx_l3_locator.sv ====
// ----------------------------------------------------------------
// Receive layer-3 start locator.
// ----------------------------------------------------------------
// Counts bytes of each received frame and flags the byte at which the
// receive checksum starts: byte 14 in fixed mode, or after any VLAN tags
// and SNAP header in adaptive mode. Stacked VLAN tags are recognised while the 5-bit start stays under 32,
// with the header walk a single comparison per field.
module rx_l3_locator (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic adaptive,
	input wire coe_wake_pkg::rx_byte_t rx_in,
	output logic csum_start
);

	logic [10:0] pos_r;
	logic [4:0] start_r;
	logic [4:0] start_nxt;
	logic [7:0] prev_r;
	logic [15:0] word;
	logic [10:0] cur_pos;
	logic is_vlan;
	logic is_len;
	logic is_snap;
	logic [4:0] base;

	// Position of the incoming byte; the first byte of a frame is zero.
	assign cur_pos = rx_in.sof ? 11'h000 : pos_r;
	assign word = {prev_r, rx_in.data};
	assign base = start_r;

	// Header field decode: VLAN and length tested when the type/length field completes, SNAP on the byte after it.
	assign is_vlan = adaptive && word == coe_wake_pkg::vlan_tpid;
	assign is_len = adaptive && word <= coe_wake_pkg::max_len_field;
	assign is_snap = rx_in.data == coe_wake_pkg::snap_llc_byte;

	// Start offset grows as tags are found; fixed mode never moves it.
	always_comb begin
		start_nxt = rx_in.sof ? coe_wake_pkg::fixed_l3_offset : start_r;
		if (rx_in.valid && cur_pos == 11'({6'h00, base} - 11'h001)) begin
			if (is_vlan) begin
				start_nxt = base + coe_wake_pkg::vlan_tag_len;
			end else if (is_len) begin
				start_nxt = base + coe_wake_pkg::snap_hdr_len;
			end
		end
		// A length field without an LLC/SNAP header rolls back.
		if (rx_in.valid && adaptive && start_r > coe_wake_pkg::fixed_l3_offset
			&& cur_pos == 11'({6'h00, base} - 11'h008) && !is_snap
			&& !(start_r == coe_wake_pkg::fixed_l3_offset
			+ coe_wake_pkg::vlan_tag_len)) begin
			start_nxt = base - coe_wake_pkg::snap_hdr_len;
		end
	end

	// Pulse on the first checksummed byte.
	assign csum_start = rx_in.valid && cur_pos == {6'h00, start_r};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_r <= 11'h000;
			start_r <= coe_wake_pkg::fixed_l3_offset;
			prev_r <= 8'h00;
		end else begin
			start_r <= start_nxt;
			if (rx_in.valid) begin
				pos_r <= cur_pos + 11'h001;
				prev_r <= rx_in.data;
			end
		end
	end

endmodule : rx_l3_locator

// ==== verif/coe_wake_cfg_checker.sv ====
// ----------------------------------------------------------------
// Protocol and behaviour checker for the offload and wake block.
// ----------------------------------------------------------------
module coe_wake_cfg_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire coe_wake_pkg::rx_byte_t rx_in,
	input wire logic lpi_removed,
	input wire coe_wake_pkg::coe_cfg_t cfg,
	input wire logic rx_csum_start,
	input wire logic tx_hold
);
	logic [5:0] idx_r;
	logic [5:0] idx;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Index of the current byte; sof restarts it so a short frame cannot skew it.
	assign idx = rx_in.sof ? 6'h00 : idx_r;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			idx_r <= 6'h00;
		else if (rx_in.valid)
			idx_r <= idx + 6'h01;
	end

	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read response late");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	AST_START_NEEDS_EN: assert property (
		rx_csum_start |-> cfg.rx_engine_enable && rx_in.valid)
		else $error("start pulse while bypassed");
	AST_FIXED_AT_14: assert property (
		cfg.rx_engine_enable && !cfg.rx_start_select && rx_in.valid &&
		idx == 6'h0E |-> rx_csum_start) else $error("no start at 14");
	AST_FIXED_ONLY_14: assert property (
		rx_csum_start && !cfg.rx_start_select |-> idx == 6'h0E)
		else $error("fixed start off 14");
	AST_ADAPT_POS: assert property (
		rx_csum_start && cfg.rx_start_select |->
		idx inside {6'h0E, 6'h12, 6'h16}) else $error("bad layer-3 start");
	AST_CFG_BY_WRITE: assert property (
		!$stable(cfg) |-> $rose(s_axi_bvalid)) else $error("cfg moved alone");
	AST_HOLD_CAUSE: assert property (
		$rose(tx_hold) |-> $past(lpi_removed)) else $error("hold uncaused");
	AST_HOLD_MIN: assert property (
		lpi_removed ##1 tx_hold |=> tx_hold [*8]) else $error("hold too short");
endmodule : coe_wake_cfg_checker

bind coe_wake_cfg coe_wake_cfg_checker coe_wake_cfg_checker_i (.aclk,
	.aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .rx_in, .lpi_removed, .cfg, .rx_csum_start,
	.tx_hold);

// ==== verif/mac_phy_model.sv ====
// ----------------------------------------------------------------
// Far-side model: receive byte stream and idle-removal pulse.
// ----------------------------------------------------------------
module mac_phy_model (
	input wire logic aclk,
	output coe_wake_pkg::rx_byte_t rx_in,
	output logic lpi_removed,
	input wire logic rx_csum_start
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		rx_in = '0;
		lpi_removed = 1'b0;
	end

	// Kind 0 plain, 1 one VLAN tag, 2 SNAP; hit is the pulsed byte or -1.
	task automatic send(input int kind, output int hit);
		logic [7:0] f [30];
		for (int i = 0; i < 30; i++)
			f[i] = 8'(i * 37);
		f[12] = kind == 1 ? 8'h81 : (kind == 2 ? 8'h00 : 8'h08);
		f[13] = kind == 2 ? 8'h40 : 8'h00;
		f[16] = 8'h08;
		f[17] = 8'h00;
		if (kind == 2) begin
			f[14] = 8'hAA;
			f[15] = 8'hAA;
		end
		hit = -1;
		for (int i = 0; i < 30; i++) begin
			@(posedge aclk);
			rx_in <= '{1'b1, i == 0, f[i]};
			#1 if (rx_csum_start && hit < 0) hit = i;
		end
		// Idle data is inverted so a stale byte never looks valid.
		@(posedge aclk);
		rx_in <= '{1'b0, 1'b0, ~f[29]};
	endtask : send

	task automatic pulse();
		@(posedge aclk);
		lpi_removed <= 1'b1;
		@(posedge aclk);
		lpi_removed <= 1'b0;
	endtask : pulse
endmodule : mac_phy_model

// ==== verif/tb_coe_wake_cfg.sv ====
module tb_coe_wake_cfg;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [9:0] s_axi_awaddr = '0;
	logic [9:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, lpi_removed, rx_csum_start, tx_hold;
	coe_wake_pkg::rx_byte_t rx_in;
	coe_wake_pkg::coe_cfg_t cfg;
	int fails = 0, cmp_count = 0, cycles = 0, hit;
	integer seed = 32'hf61e;
	logic [31:0] d, q;
	// Byte addresses are four times the word index of each register.
	localparam logic [9:0] coe_addr =
		{coe_wake_pkg::checksum_offload_control_idx, 2'b00};
	localparam logic [9:0] wait_addr =
		{coe_wake_pkg::post_idle_tx_wait_time_idx, 2'b00};
	// Word just past the map, for the unmapped-access checks.
	localparam logic [9:0] bad_addr = 10'h03C;

	coe_wake_cfg coe_wake_cfg_i (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in,
		.lpi_removed, .cfg, .rx_csum_start, .tx_hold);
	mac_phy_model mac_phy_model_i (.aclk, .rx_in, .lpi_removed,
		.rx_csum_start);

	// Clock, and a cycle ceiling well above the idle-wait run.
	initial forever #10 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	// Expected start byte: none when bypassed, else after any skipped header.
	function automatic logic [31:0] pos_exp(input logic [1:0] c, input int k);
		logic [4:0] s;
		if (!c[0])
			return '1;
		s = coe_wake_pkg::fixed_l3_offset;
		if (c[1] && k == 1)
			s = s + coe_wake_pkg::vlan_tag_len;
		if (c[1] && k == 2)
			s = s + coe_wake_pkg::snap_hdr_len;
		return 32'(s);
	endfunction : pos_exp

	// Expected hold length in clocks for a wait of w microseconds.
	function automatic logic [31:0] hold_exp(input logic [23:0] w);
		return 32'(w) * 32'(coe_wake_pkg::cycles_per_us);
	endfunction : hold_exp

	// Counts the clocks for which the hold stays up after one pulse.
	task automatic hold_cycles(output int n);
		mac_phy_model_i.pulse();
		n = 0;
		#1 while (tx_hold === 1'b1 && n < 5000) begin
			n++;
			@(posedge aclk);
			#1;
		end
	endtask : hold_cycles

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Address and data go out together; each is dropped once taken.
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		q = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(coe_addr);
		chk(q, 32'h0000_0000);
		rd(wait_addr);
		chk(q, 32'h0000_001E);
		// Idle removal at the reset wait: 30 us of 50 clocks each.
		hold_cycles(hit);
		chk(32'(hit), hold_exp(coe_wake_pkg::wait_time_reset));
		// Random register traffic; the first pass writes all ones.
		for (int i = 0; i < 5; i++) begin
			d = i == 0 ? '1 : $random(seed);
			wr(coe_addr, d);
			chk(32'(cfg), {29'h0, d[16], d[1], d[0]});
			rd(coe_addr);
			chk(q, d & 32'h0001_0003);
			d = i == 0 ? '1 : $random(seed);
			wr(wait_addr, d);
			chk(32'(r), 32'h0000_0000);
			rd(wait_addr);
			chk(q, d & 32'h00FF_FFFF);
			chk(32'(r), 32'h0000_0000);
		end
		wr(bad_addr, '1);
		chk(32'(r), 32'h0000_0002);
		rd(bad_addr);
		chk(q, 32'h0000_0000);
		chk(32'(r), 32'h0000_0002);
		// A programmed wait at or above the recommended floor.
		wr(wait_addr, 32'h0000_0020);
		hold_cycles(hit);
		chk(32'(hit), hold_exp(24'h000020));
		// Partial strobe: only the low byte lane of the wait is written.
		s_axi_wstrb <= 4'h1;
		wr(wait_addr, 32'hFFFF_FF55);
		s_axi_wstrb <= 4'hF;
		rd(wait_addr);
		chk(q, 32'h0000_0055);
		// Control changes only between frames, with the receive path idle.
		for (int j = 0; j < 4; j++) begin
			wr(coe_addr, 32'(j));
			for (int k = 0; k < 3; k++) begin
				mac_phy_model_i.send(k, hit);
				chk(32'(hit), pos_exp(2'(j), k));
			end
		end
		end_of_test();
	end
endmodule : tb_coe_wake_cfg
